// ==== rtl/eoss_pkg.sv ====
package eoss_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [7:0] ADDR_CLOCK_SOURCE = 8'hA9;
    localparam logic [7:0] ADDR_EXT_OSC_CTRL = 8'hB1;
    localparam logic [7:0] ADDR_INT_OSC_CTRL = 8'hB2;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CRYSTAL_VALID_BIT = 7;
    localparam int EXT_MODE_HI = 6;
    localparam int EXT_MODE_LO = 4;
    localparam int EXT_RANGE_HI = 2;
    localparam int EXT_RANGE_LO = 0;
    localparam int INT_ENABLE_BIT = 7;
    localparam int INT_READY_BIT = 6;
    localparam int INT_DIV_HI = 1;
    localparam int INT_DIV_LO = 0;
    localparam int SRC_SELECT_BIT = 0;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [2:0] EXT_MODE_RESET = 3'h0;
    localparam logic [2:0] EXT_RANGE_RESET = 3'h0;
    localparam logic INT_ENABLE_RESET = 1'b1;
    localparam logic [1:0] INT_DIV_RESET = 2'h0;
    localparam logic SRC_SELECT_RESET = 1'b0;

    // ********************************************************
    // External oscillator modes
    // ********************************************************
    typedef enum logic [2:0] {
        EOSS_MODE_OFF0 = 3'b000,
        EOSS_MODE_OFF1 = 3'b001,
        EOSS_MODE_CMOS = 3'b010,
        EOSS_MODE_CMOS_DIV2 = 3'b011,
        EOSS_MODE_RC = 3'b100,
        EOSS_MODE_CAP = 3'b101,
        EOSS_MODE_XTAL = 3'b110,
        EOSS_MODE_XTAL_DIV2 = 3'b111
    } eoss_mode_t;

    // Internal divider codes
    localparam logic [1:0] INT_DIV_BY8 = 2'h0;
    localparam logic [1:0] INT_DIV_BY4 = 2'h1;
    localparam logic [1:0] INT_DIV_BY2 = 2'h2;
    localparam logic [1:0] INT_DIV_BY1 = 2'h3;

    // Oscillator edges counted before the crystal counts as settled
    localparam logic [10:0] XTAL_SETTLE_EDGES = 11'h400;

endpackage : eoss_pkg

// ==== rtl/eoss_clock_control.sv ====
`timescale 1ns/1ps

module eoss_clock_control
    import eoss_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic int_osc_in,
    input wire logic crystal_output_pin_in,
    output logic system_clock_out,
    output logic ext_periph_clk,
    output logic int_osc_enable_out,
    output logic [2:0] ext_osc_mode_out,
    output logic [2:0] ext_osc_range_out,
    output logic crystal_input_pin_claim,
    output logic crystal_output_pin_claim
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [2:0] ext_mode;
        logic [2:0] ext_range;
        logic int_enable;
        logic [1:0] int_div;
        logic src_req;
        logic src_cur;
        logic parked;
        logic crystal_valid;
        logic [10:0] settle_cnt;
        logic int_prev;
        logic [2:0] int_cnt;
        logic int_clk;
        logic ext_prev;
        logic ext_half;
        logic ext_clk;
        logic system_clock;
        logic xin_claim;
        logic xout_claim;
        logic [7:0] rdata;
    } eoss_state_t;

    eoss_state_t st_r;
    eoss_state_t st_nxt;
    logic xtal_mode;
    logic ext_off;
    logic int_rise;
    logic ext_rise;
    logic [2:0] cnt_inc;
    logic old_clk;
    logic new_clk;

    assign xtal_mode = (st_r.ext_mode[2:1] == EOSS_MODE_XTAL[2:1]);
    assign ext_off = (st_r.ext_mode[2:1] == EOSS_MODE_OFF0[2:1]);
    assign int_rise = int_osc_in && !st_r.int_prev;
    assign ext_rise = crystal_output_pin_in && !st_r.ext_prev;
    assign cnt_inc = st_r.int_cnt + 3'h1;
    // Level of the source in use and of the one asked for
    assign old_clk = st_r.src_cur ? st_r.ext_clk : st_r.int_clk;
    assign new_clk = st_r.src_req ? st_r.ext_clk : st_r.int_clk;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.int_prev = int_osc_in;
        st_nxt.ext_prev = crystal_output_pin_in;

        // Register writes; unused and reserved bits are dropped
        if (sfr_wr && sfr_addr == ADDR_EXT_OSC_CTRL) begin
            st_nxt.ext_mode = sfr_wdata[EXT_MODE_HI:EXT_MODE_LO];
            st_nxt.ext_range = sfr_wdata[EXT_RANGE_HI:EXT_RANGE_LO];
        end else if (sfr_wr && sfr_addr == ADDR_INT_OSC_CTRL) begin
            st_nxt.int_enable = sfr_wdata[INT_ENABLE_BIT];
            st_nxt.int_div = sfr_wdata[INT_DIV_HI:INT_DIV_LO];
        end else if (sfr_wr && sfr_addr == ADDR_CLOCK_SOURCE) begin
            st_nxt.src_req = sfr_wdata[SRC_SELECT_BIT];
        end

        // Read mux, registered; unmapped addresses read zero
        st_nxt.rdata = 8'h00;
        if (sfr_rd && sfr_addr == ADDR_EXT_OSC_CTRL) begin
            st_nxt.rdata[CRYSTAL_VALID_BIT] = st_r.crystal_valid;
            st_nxt.rdata[EXT_MODE_HI:EXT_MODE_LO] = st_r.ext_mode;
            st_nxt.rdata[EXT_RANGE_HI:EXT_RANGE_LO] = st_r.ext_range;
        end else if (sfr_rd && sfr_addr == ADDR_INT_OSC_CTRL) begin
            st_nxt.rdata[INT_ENABLE_BIT] = st_r.int_enable;
            // Ready needs no settle time, so it mirrors the enable
            st_nxt.rdata[INT_READY_BIT] = st_r.int_enable;
            st_nxt.rdata[INT_DIV_HI:INT_DIV_LO] = st_r.int_div;
        end else if (sfr_rd && sfr_addr == ADDR_CLOCK_SOURCE) begin
            st_nxt.rdata[SRC_SELECT_BIT] = st_r.src_req;
        end

        // Crystal settle detector: counts oscillator edges, restarts outside 11x
        if (!xtal_mode) begin
            st_nxt.settle_cnt = 11'h000;
            st_nxt.crystal_valid = 1'b0;
        end else if (st_r.settle_cnt == XTAL_SETTLE_EDGES) begin
            st_nxt.crystal_valid = 1'b1;
        end else if (ext_rise) begin
            st_nxt.settle_cnt = st_r.settle_cnt + 11'h001;
        end

        // Internal path and divider; disabled oscillator parks low
        if (int_rise) begin
            st_nxt.int_cnt = cnt_inc;
        end
        if (!st_r.int_enable) begin
            st_nxt.int_clk = 1'b0;
        end else begin
            case (st_r.int_div)
                INT_DIV_BY8: st_nxt.int_clk = st_r.int_cnt[2];
                INT_DIV_BY4: st_nxt.int_clk = st_r.int_cnt[1];
                INT_DIV_BY2: st_nxt.int_clk = st_r.int_cnt[0];
                default: st_nxt.int_clk = int_osc_in;
            endcase
        end

        // External path per mode
        if (ext_rise) begin
            st_nxt.ext_half = !st_r.ext_half;
        end
        case (eoss_mode_t'(st_r.ext_mode))
            EOSS_MODE_CMOS: st_nxt.ext_clk = crystal_output_pin_in;
            EOSS_MODE_CMOS_DIV2: st_nxt.ext_clk = st_r.ext_half;
            EOSS_MODE_RC: st_nxt.ext_clk = crystal_output_pin_in;
            EOSS_MODE_CAP: st_nxt.ext_clk = crystal_output_pin_in;
            EOSS_MODE_XTAL: st_nxt.ext_clk = crystal_output_pin_in;
            EOSS_MODE_XTAL_DIV2: st_nxt.ext_clk = st_r.ext_half;
            default: st_nxt.ext_clk = 1'b0;
        endcase

        // Pin claims
        st_nxt.xin_claim = xtal_mode;
        st_nxt.xout_claim = !ext_off;

        // Two-step switch: park low once the old source is low, then take the new one when it is low.
        // Equal-rate clocks in opposite phase never sit low together, so a one-step test could hang.
        if (!st_r.parked && st_r.src_req != st_r.src_cur && !old_clk) begin
            st_nxt.parked = 1'b1;
        end else if (st_r.parked && !new_clk) begin
            st_nxt.src_cur = st_r.src_req;
            st_nxt.parked = 1'b0;
        end
        if (st_r.parked) begin
            st_nxt.system_clock = 1'b0;
        end else begin
            st_nxt.system_clock = old_clk;
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.ext_mode <= EXT_MODE_RESET;
            st_r.ext_range <= EXT_RANGE_RESET;
            st_r.int_enable <= INT_ENABLE_RESET;
            st_r.int_div <= INT_DIV_RESET;
            st_r.src_req <= SRC_SELECT_RESET;
            st_r.src_cur <= SRC_SELECT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata = st_r.rdata;
    assign system_clock_out = st_r.system_clock;
    assign ext_periph_clk = st_r.ext_clk;
    assign int_osc_enable_out = st_r.int_enable;
    assign ext_osc_mode_out = st_r.ext_mode;
    assign ext_osc_range_out = st_r.ext_range;
    assign crystal_input_pin_claim = st_r.xin_claim;
    assign crystal_output_pin_claim = st_r.xout_claim;

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_system_clock_source;
        @(posedge clk) disable iff (reset)
        1'b1 |=> system_clock_out ==
            (!$past(st_r.parked) && ($past(st_r.src_cur) ? $past(st_r.ext_clk) : $past(st_r.int_clk)));
    endproperty
    a_system_clock_source: assert property (p_system_clock_source) else $error("system clock from wrong source");

    property p_no_glitch;
        @(posedge clk) disable iff (reset)
        $changed(st_r.src_cur) |->
            $past(st_r.parked) && !(st_r.src_cur ? $past(st_r.ext_clk) : $past(st_r.int_clk));
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("source switched while a clock was high");

    property p_park_entry;
        @(posedge clk) disable iff (reset)
        $rose(st_r.parked) |-> !($past(st_r.src_cur) ? $past(st_r.ext_clk) : $past(st_r.int_clk));
    endproperty
    a_park_entry: assert property (p_park_entry) else $error("output parked while old source high");

    property p_ext_off;
        @(posedge clk) disable iff (reset)
        ext_off |=> !ext_periph_clk;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external clock active while off");

    property p_valid_needs_xtal;
        @(posedge clk) disable iff (reset)
        !xtal_mode |=> !st_r.crystal_valid;
    endproperty
    a_valid_needs_xtal: assert property (p_valid_needs_xtal) else $error("valid flag outside crystal mode");

    property p_valid_after_settle;
        @(posedge clk) disable iff (reset)
        xtal_mode && st_r.settle_cnt == XTAL_SETTLE_EDGES ##1 xtal_mode |-> st_r.crystal_valid;
    endproperty
    a_valid_after_settle: assert property (p_valid_after_settle) else $error("valid flag not set after settle");

    property p_read_ext_ctrl;
        @(posedge clk) disable iff (reset)
        sfr_rd && sfr_addr == ADDR_EXT_OSC_CTRL |=>
            !sfr_rdata[3] && sfr_rdata[CRYSTAL_VALID_BIT] == $past(st_r.crystal_valid);
    endproperty
    a_read_ext_ctrl: assert property (p_read_ext_ctrl) else $error("bad external control readback");

    property p_int_disabled;
        @(posedge clk) disable iff (reset)
        !st_r.int_enable |=> !st_r.int_clk ##1 !system_clock_out || $past(st_r.src_cur);
    endproperty
    a_int_disabled: assert property (p_int_disabled) else $error("internal clock runs while disabled");

    property p_pin_claims;
        @(posedge clk) disable iff (reset)
        1'b1 |=> crystal_input_pin_claim == $past(xtal_mode) && crystal_output_pin_claim == !$past(ext_off);
    endproperty
    a_pin_claims: assert property (p_pin_claims) else $error("oscillator pin claim wrong");

    property p_select_write;
        @(posedge clk) disable iff (reset)
        sfr_wr && sfr_addr == ADDR_CLOCK_SOURCE |=> st_r.src_req == $past(sfr_wdata[SRC_SELECT_BIT]);
    endproperty
    a_select_write: assert property (p_select_write) else $error("source select write lost");

    property p_div1;
        @(posedge clk) disable iff (reset)
        st_r.int_enable && st_r.int_div == INT_DIV_BY1 |=> st_r.int_clk == $past(int_osc_in);
    endproperty
    a_div1: assert property (p_div1) else $error("divide by one path wrong");

    c_switch_ext: cover property (@(posedge clk) disable iff (reset) $rose(st_r.src_cur));
    c_switch_int: cover property (@(posedge clk) disable iff (reset) $fell(st_r.src_cur));
    c_xtal_valid: cover property (@(posedge clk) disable iff (reset) $rose(st_r.crystal_valid));

endmodule // eoss_clock_control

// ==== verif/eoss_osc_model.sv ====
`timescale 1ns/1ps

// ********************************************************
// Far-side oscillator: crystal, RC, capacitor or CMOS clock
// ********************************************************
module eoss_osc_model (
    input wire logic clk,
    input wire logic run,
    input wire logic drive,
    output logic pin
);
    // Oscillates only while the drive circuit is on; a dead part parks the pin low.
    // The drive circuit is off during reset, which clears the pin.
    always @(posedge clk) begin
        pin <= (run && drive) ? ~pin : 1'b0;
    end
endmodule // eoss_osc_model

// ==== verif/tb_ext_oscillator_system_clock_select.sv ====
`timescale 1ns/1ps

module tb_ext_oscillator_system_clock_select
    import eoss_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic int_osc_in = 1'b0;
    logic run = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic system_clock_out, ext_periph_clk, int_osc_enable_out, pin;
    logic crystal_input_pin_claim, crystal_output_pin_claim;
    logic [2:0] ext_osc_mode_out, ext_osc_range_out;
    logic [31:0] seed = 32'h06C1;
    logic [7:0] d;
    int num_errors = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    eoss_clock_control DUT (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .int_osc_in(int_osc_in),
        .crystal_output_pin_in(pin), .system_clock_out(system_clock_out), .ext_periph_clk(ext_periph_clk),
        .int_osc_enable_out(int_osc_enable_out), .ext_osc_mode_out(ext_osc_mode_out),
        .ext_osc_range_out(ext_osc_range_out), .crystal_input_pin_claim(crystal_input_pin_claim),
        .crystal_output_pin_claim(crystal_output_pin_claim));

    // Pins left to the oscillator only while claimed
    eoss_osc_model osc (.clk(clk), .run(run), .drive(crystal_output_pin_claim), .pin(pin));

    // Internal oscillator stand-in, half the bus clock, parked low when disabled
    always @(posedge clk) begin
        int_osc_in <= int_osc_enable_out ? ~int_osc_in : 1'b0;
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Bit 3 never stored, bit 7 owned by hardware
    function automatic logic [7:0] b1_exp(input logic [7:0] w, input logic v);
        return {v, w[6:4], 1'b0, w[2:0]};
    endfunction

    function automatic logic [7:0] claims(input logic [2:0] m);
        return {6'h00, m[2:1] == 2'b11, m[2:1] != 2'b00};
    endfunction

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // Read data is registered, so it is looked at just after the taking edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata, e);
    endtask

    // Rising edges over 80 cycles; one edge of slack for the switch point
    task automatic span(input int es, input int ee);
        logic ps, pe;
        int a, b;
        a = 0;
        b = 0;
        repeat (10) @(posedge clk);
        #1;
        ps = system_clock_out;
        pe = ext_periph_clk;
        repeat (80) begin
            @(posedge clk);
            #1;
            a += int'(system_clock_out && !ps);
            b += int'(ext_periph_clk && !pe);
            ps = system_clock_out;
            pe = ext_periph_clk;
        end
        chk((a >= es - 1 && a <= es + 1) ? 8'h01 : 8'h00, 8'h01);
        chk((b >= ee - 1 && b <= ee + 1) ? 8'h01 : 8'h00, 8'h01);
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd_chk(ADDR_CLOCK_SOURCE, 8'h00);
        rd_chk(ADDR_EXT_OSC_CTRL, 8'h00);
        rd_chk(ADDR_INT_OSC_CTRL, 8'hC0);
        rd_chk(8'hB3, 8'h00);
        chk({7'h00, int_osc_enable_out}, 8'h01);
        for (int m = 0; m < 8; m++) begin
            d = rnd();
            d[6:4] = 3'(m);
            wr(ADDR_EXT_OSC_CTRL, d);
            repeat (2) @(posedge clk);
            rd_chk(ADDR_EXT_OSC_CTRL, b1_exp(d, 1'b0));
            chk({2'h0, ext_osc_mode_out, ext_osc_range_out}, {2'h0, d[6:4], d[2:0]});
            chk({6'h00, crystal_input_pin_claim, crystal_output_pin_claim}, claims(d[6:4]));
        end
        wr(8'hB3, rnd());
        wr(ADDR_CLOCK_SOURCE, 8'hFE);
        rd_chk(ADDR_CLOCK_SOURCE, 8'h00);
        wr(ADDR_EXT_OSC_CTRL, 8'h20);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_INT_OSC_CTRL, 8'h80 | 8'(k));
            span(40 >> (3 - k), 40);
        end
        wr(ADDR_EXT_OSC_CTRL, 8'h30);
        wr(ADDR_INT_OSC_CTRL, 8'h03);
        rd_chk(ADDR_INT_OSC_CTRL, 8'h03);
        span(0, 20);
        wr(ADDR_CLOCK_SOURCE, 8'h01);
        span(20, 20);
        wr(ADDR_INT_OSC_CTRL, 8'h83);
        wr(ADDR_CLOCK_SOURCE, 8'h00);
        span(40, 20);
        // Dead crystal first, then a live one counting towards settle
        @(posedge clk) run <= 1'b0;
        wr(ADDR_EXT_OSC_CTRL, 8'h67);
        repeat (2200) @(posedge clk);
        rd_chk(ADDR_EXT_OSC_CTRL, 8'h67);
        @(posedge clk) run <= 1'b1;
        repeat (1900) @(posedge clk);
        rd_chk(ADDR_EXT_OSC_CTRL, 8'h67);
        repeat (300) @(posedge clk);
        rd_chk(ADDR_EXT_OSC_CTRL, 8'hE7);
        wr(ADDR_EXT_OSC_CTRL, 8'h6F);
        rd_chk(ADDR_EXT_OSC_CTRL, 8'hE7);
        // Slow internal clock, so the edge count tells the two sources apart
        wr(ADDR_INT_OSC_CTRL, 8'h80);
        wr(ADDR_CLOCK_SOURCE, 8'h01);
        span(40, 40);
        wr(ADDR_CLOCK_SOURCE, 8'h00);
        wr(ADDR_EXT_OSC_CTRL, 8'h47);
        rd_chk(ADDR_EXT_OSC_CTRL, 8'h47);
        stop_test();
    end

    // Run needs about 5200 cycles; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule // tb_ext_oscillator_system_clock_select
